// ### srcp_pkg.sv
// Shared constants and types of the serial register control port, plus the
// two-flip-flop synchroniser used at the clock-domain boundary.
// Assumes a host serial master that frames each cycle with a low select.
// Functional notes
// - Each cycle opens with an instruction byte on eight rising serial edges.
// - Instruction bit 7 high asks for a read, low for a write.
// - Instruction bits 6 and 5 give one to four data bytes.
// - Low five instruction bits give start address; device steps the rest.
// - A written register updates when the last bit of its byte lands.
// - Bits are captured on rising edges and launched on falling edges.
// - Select low starts and gates a cycle and stays low throughout.
// - With select high both data pins float.
// - Register 0 bit 7 picks separate output pin or shared two-way pin.
// - In shared-pin mode the separate output pin never drives.
// - Register 0 bit 6 set shifts every byte least significant bit first.
// - Most significant bit first: start at top byte, address counts down.
// - Least significant bit first: start at bottom byte, address counts up.
// - Address stepping wraps within the five-bit space.
// - Software reset defaults every register except register 0.
// - Palindromic register 0 pattern restores lost configuration and resets.
`timescale 1ns/10ps
package srcp_pkg;
    localparam int ADDR_W = 5;
    localparam int BYTE_W = 8;
    localparam int IMG_W = 256;
    localparam int SCLK_MAX_MHZ = 15;
    localparam logic [4:0] CFG_ADDR = 5'h00;
    localparam int CFG_BIDIR_BIT = 7;
    localparam int CFG_LSB_BIT = 6;
    localparam int CFG_RST_BIT = 5;
    localparam int INSTR_RD_BIT = 7;
    localparam int INSTR_CNT_HI = 6;
    localparam int INSTR_CNT_LO = 5;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [255:0] RESET_IMAGE = 256'h0;

    typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} srcp_phase_t;

    typedef struct packed {
        srcp_phase_t phase;
        logic rd;
        logic [1:0] left;
        logic [4:0] addr;
        logic [2:0] cnt;
        logic [7:0] sh;
    } srcp_frame_t;

    typedef struct packed {
        logic [255:0] regs;
        logic wr_tgl;
        logic [4:0] wr_addr;
        logic [7:0] wr_data;
    } srcp_rfile_t;

    typedef struct packed {
        logic sdio_out;
        logic sdio_oe;
        logic sdo_out;
        logic sdo_oe;
        logic [7:0] osh;
    } srcp_drv_t;

    typedef struct packed {
        logic tgl_prev;
        logic wr_strobe;
        logic [4:0] wr_addr;
        logic [7:0] wr_data;
        logic soft_rst;
        logic [255:0] image;
    } srcp_core_t;

    localparam srcp_frame_t FRAME_IDLE = '{PH_INSTR, 1'b0, 2'h0, 5'h00,
                                           3'h0, 8'h00};
    localparam srcp_rfile_t RFILE_RESET = '{RESET_IMAGE, 1'b0, 5'h00, 8'h00};
    localparam srcp_drv_t DRV_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    localparam srcp_core_t CORE_RESET = '{1'b0, 1'b0, 5'h00, 8'h00, 1'b0,
                                          RESET_IMAGE};
endpackage

module srcp_sync #(
    parameter int STAGES = 2
) (
    // Destination clock and synchronous reset.
    input logic clk,
    input logic rst_n,
    // Level from the other domain and its synchronised copy.
    input logic d,
    output logic q
);
    typedef struct packed {
        logic [STAGES-1:0] chain;
    } srcp_sync_t;

    srcp_sync_t s;
    srcp_sync_t next_s;

    // Refused at elaboration: one stage would expose a metastable flop.
    if (STAGES < 2) begin
        $error("srcp_sync needs at least two stages");
    end

    // Only the last stage is visible, so the metastable first stage feeds
    // nothing but the next flip-flop.
    always_comb begin
        next_s.chain = {s.chain[STAGES-2:0], d};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.chain[STAGES-1];
endmodule

// ### srcp_top.sv
// Serial register control port: a slave shift engine on the host's serial
// clock holding the register file, and a core-clock view of every write.
// Assumes the host serial clock runs within select-low frames, and with select high only around reset.
`timescale 1ns/10ps
module srcp_top (
    // Core clock domain.
    input logic core_clk,
    input logic nrst,
    // Serial link.
    input logic sclk,
    input logic cs_n,
    input logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic sdo_out,
    output logic sdo_oe,
    // Register write events in the core domain.
    output logic wr_strobe,
    output logic [4:0] wr_addr,
    output logic [7:0] wr_data,
    output logic soft_rst,
    // Configuration and register view in the core domain.
    output logic cfg_bidir,
    output logic cfg_lsb_first,
    output logic [255:0] reg_image
);
    srcp_pkg::srcp_frame_t fr;
    srcp_pkg::srcp_frame_t next_fr;
    srcp_pkg::srcp_rfile_t rf;
    srcp_pkg::srcp_rfile_t next_rf;
    srcp_pkg::srcp_drv_t dv;
    srcp_pkg::srcp_drv_t next_dv;
    srcp_pkg::srcp_core_t c;
    srcp_pkg::srcp_core_t next_c;
    logic rst_link;
    logic tgl_s;
    logic lsb;
    logic bidir;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [7:0] cfg_byte;

    // Core reset reaches the link register file only on serial clock edges.
    srcp_sync #(.STAGES(2)) u_rst_sync (
        .clk(sclk),
        .rst_n(1'b1),
        .d(nrst),
        .q(rst_link)
    );

    // The write toggle is the only event crossing into the core domain.
    srcp_sync #(.STAGES(2)) u_tgl_sync (
        .clk(core_clk),
        .rst_n(nrst),
        .d(rf.wr_tgl),
        .q(tgl_s)
    );

    assign lsb = rf.regs[srcp_pkg::CFG_LSB_BIT];
    assign bidir = rf.regs[srcp_pkg::CFG_BIDIR_BIT];
    assign rd_byte = rf.regs[{fr.addr, 3'h0} +: 8];

    // Register 0 keeps its bits except the reset bit, which self-clears.
    always_comb begin
        cfg_byte = byte_in;
        cfg_byte[srcp_pkg::CFG_RST_BIT] = 1'b0;
    end

    always_comb begin
        byte_in = lsb ? {sdio_in, fr.sh[7:1]}
                      : {fr.sh[6:0], sdio_in};
        next_fr = fr;
        next_rf = rf;
        next_fr.sh = byte_in;
        next_fr.cnt = fr.cnt + 3'h1;
        case (fr.phase)
            srcp_pkg::PH_INSTR: begin
                if (fr.cnt == srcp_pkg::LAST_BIT) begin
                    next_fr.rd = byte_in[srcp_pkg::INSTR_RD_BIT];
                    next_fr.left = byte_in[srcp_pkg::INSTR_CNT_HI:
                                           srcp_pkg::INSTR_CNT_LO];
                    next_fr.addr = byte_in[4:0];
                    next_fr.phase = srcp_pkg::PH_DATA;
                end
            end
            srcp_pkg::PH_DATA: begin
                if (fr.cnt == srcp_pkg::LAST_BIT) begin
                    if (!fr.rd) begin
                        // Each byte lands at once; later bytes of the same
                        // cycle see any new port configuration.
                        next_rf.regs[{fr.addr, 3'h0} +: 8] = byte_in;
                        next_rf.wr_tgl = ~rf.wr_tgl;
                        next_rf.wr_addr = fr.addr;
                        next_rf.wr_data = byte_in;
                        if (fr.addr == srcp_pkg::CFG_ADDR) begin
                            next_rf.regs[7:0] = cfg_byte;
                            // A palindromic pattern reads the same in both
                            // bit orders, so it repairs a lost setting.
                            if (byte_in[srcp_pkg::CFG_RST_BIT]) begin
                                next_rf.regs[255:8] =
                                    srcp_pkg::RESET_IMAGE[255:8];
                            end
                        end
                    end
                    // Five-bit arithmetic wraps between 1Fh and 00h.
                    if (lsb) begin
                        next_fr.addr = fr.addr + 5'h01;
                    end else begin
                        next_fr.addr = fr.addr - 5'h01;
                    end
                    if (fr.left == 2'h0) begin
                        next_fr.phase = srcp_pkg::PH_DONE;
                    end else begin
                        next_fr.left = fr.left - 2'h1;
                    end
                end
            end
            default: begin
                // Extra clocks after the last byte are ignored.
                next_fr.cnt = fr.cnt;
            end
        endcase
    end

    // Select high drops any partial cycle without needing a clock edge.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fr <= srcp_pkg::FRAME_IDLE;
        end else begin
            fr <= next_fr;
        end
    end

    always_ff @(posedge sclk) begin
        if (!rst_link) begin
            rf <= srcp_pkg::RFILE_RESET;
        end else if (!cs_n) begin
            rf <= next_rf;
        end
    end

    always_comb begin
        logic drive;
        logic bit_o;
        drive = 1'b0;
        bit_o = 1'b0;
        next_dv = dv;
        if (fr.phase == srcp_pkg::PH_DATA && fr.rd) begin
            drive = 1'b1;
            if (fr.cnt == 3'h0) begin
                bit_o = lsb ? rd_byte[0] : rd_byte[7];
                next_dv.osh = lsb ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
            end else begin
                bit_o = lsb ? dv.osh[0] : dv.osh[7];
                next_dv.osh = lsb ? {1'b0, dv.osh[7:1]} : {dv.osh[6:0], 1'b0};
            end
        end
        next_dv.sdio_oe = drive & bidir;
        next_dv.sdo_oe = drive & ~bidir;
        next_dv.sdio_out = drive & bidir & bit_o;
        next_dv.sdo_out = drive & ~bidir & bit_o;
    end

    // Outgoing data changes on falling edges so the host samples it rising.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            dv <= srcp_pkg::DRV_IDLE;
        end else begin
            dv <= next_dv;
        end
    end

    assign sdio_out = dv.sdio_out;
    assign sdio_oe = dv.sdio_oe;
    assign sdo_out = dv.sdo_out;
    assign sdo_oe = dv.sdo_oe;

    // Address and data stay put for eight serial clocks after the toggle,
    // longer than the synchroniser delay at the permitted serial rate.
    always_comb begin
        next_c = c;
        next_c.wr_strobe = 1'b0;
        next_c.soft_rst = 1'b0;
        if (tgl_s != c.tgl_prev) begin
            next_c.tgl_prev = tgl_s;
            next_c.wr_strobe = 1'b1;
            next_c.wr_addr = rf.wr_addr;
            next_c.wr_data = rf.wr_data;
            next_c.image[{rf.wr_addr, 3'h0} +: 8] = rf.wr_data;
            if (rf.wr_addr == srcp_pkg::CFG_ADDR) begin
                next_c.image[7:0] = rf.wr_data;
                next_c.image[srcp_pkg::CFG_RST_BIT] = 1'b0;
                if (rf.wr_data[srcp_pkg::CFG_RST_BIT]) begin
                    next_c.soft_rst = 1'b1;
                    next_c.image[255:8] = srcp_pkg::RESET_IMAGE[255:8];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            c <= srcp_pkg::CORE_RESET;
        end else begin
            c <= next_c;
        end
    end

    assign wr_strobe = c.wr_strobe;
    assign wr_addr = c.wr_addr;
    assign wr_data = c.wr_data;
    assign soft_rst = c.soft_rst;
    assign cfg_bidir = c.image[srcp_pkg::CFG_BIDIR_BIT];
    assign cfg_lsb_first = c.image[srcp_pkg::CFG_LSB_BIT];
    assign reg_image = c.image;

    sequence s_instr_end;
        fr.phase == srcp_pkg::PH_INSTR && fr.cnt == srcp_pkg::LAST_BIT;
    endsequence

    sequence s_data_end;
        fr.phase == srcp_pkg::PH_DATA && fr.cnt == srcp_pkg::LAST_BIT;
    endsequence

    sequence s_read_load;
        fr.phase == srcp_pkg::PH_DATA && fr.rd && fr.cnt == 3'h0;
    endsequence

    AST_IDLE_FLOAT: assert property (@(posedge sclk)
        cs_n |-> !sdio_oe && !sdo_oe)
        else $error("data pins driven while select is high");

    AST_FRAME_DROP: assert property (@(posedge sclk)
        cs_n |-> fr.phase == srcp_pkg::PH_INSTR && fr.cnt == 3'h0)
        else $error("partial cycle survived select high");

    AST_INSTR_DECODE: assert property (@(posedge sclk)
        disable iff (cs_n)
        s_instr_end |=> fr.phase == srcp_pkg::PH_DATA
            && fr.rd == $past(byte_in[7]) && fr.left == $past(byte_in[6:5])
            && fr.addr == $past(byte_in[4:0]))
        else $error("instruction byte decoded wrongly");

    AST_WRITE_NOW: assert property (@(posedge sclk)
        disable iff (cs_n || !rst_link)
        s_data_end ##0 !fr.rd |=> rf.wr_data == $past(byte_in)
            && rf.wr_addr == $past(fr.addr) && rf.wr_tgl != $past(rf.wr_tgl))
        else $error("written byte not stored at its last bit");

    AST_ADDR_STEP: assert property (@(posedge sclk)
        disable iff (cs_n || !rst_link)
        s_data_end ##0 fr.left != 2'h0 |=> fr.addr == ($past(lsb)
            ? 5'($past(fr.addr) + 5'h01) : 5'($past(fr.addr) - 5'h01)))
        else $error("address did not step in bit order direction");

    AST_SOFT_RESET: assert property (@(posedge sclk)
        disable iff (cs_n || !rst_link)
        s_data_end ##0 (!fr.rd && fr.addr == srcp_pkg::CFG_ADDR
            && byte_in[srcp_pkg::CFG_RST_BIT]) |=> rf.regs[255:8] == 248'h0
            && rf.regs[7:6] == $past(byte_in[7:6]) && !rf.regs[5])
        else $error("software reset misapplied");

    AST_SDO_QUIET: assert property (@(negedge sclk)
        disable iff (cs_n)
        sdo_oe |-> !$past(bidir))
        else $error("separate output drove in shared-pin mode");

    AST_READ_FIRST: assert property (@(negedge sclk)
        disable iff (cs_n)
        s_read_load |=> (sdio_out | sdo_out)
            == $past(lsb ? rd_byte[0] : rd_byte[7]) && (sdio_oe ^ sdo_oe))
        else $error("read byte not launched on the expected edge");

    AST_CORE_EVENT: assert property (@(posedge core_clk)
        disable iff (!nrst)
        tgl_s != c.tgl_prev |=> wr_strobe ##1 !wr_strobe)
        else $error("write event not reported as a single pulse");

    // The core view must agree with the byte that raised the event.
    AST_CFG_MIRROR: assert property (@(posedge core_clk)
        disable iff (!nrst)
        wr_strobe && wr_addr == srcp_pkg::CFG_ADDR |->
            cfg_bidir == wr_data[srcp_pkg::CFG_BIDIR_BIT]
            && cfg_lsb_first == wr_data[srcp_pkg::CFG_LSB_BIT])
        else $error("core configuration disagrees with register 0 write");

    AST_SOFT_PULSE: assert property (@(posedge core_clk)
        disable iff (!nrst)
        soft_rst |-> wr_strobe && wr_addr == srcp_pkg::CFG_ADDR
            && reg_image[255:8] == srcp_pkg::RESET_IMAGE[255:8])
        else $error("software reset pulse without its register 0 write");

    // Data bits must never be taken before the eighth instruction bit.
    AST_INSTR_HOLD: assert property (@(posedge sclk)
        disable iff (cs_n)
        fr.phase == srcp_pkg::PH_INSTR && fr.cnt != srcp_pkg::LAST_BIT
            |=> fr.phase == srcp_pkg::PH_INSTR)
        else $error("instruction phase ended early");

    AST_READ_ONLY_DRIVE: assert property (@(negedge sclk)
        disable iff (cs_n)
        (sdio_oe || sdo_oe) |-> fr.rd)
        else $error("data pin driven outside a read");

    AST_SDIO_SHARED: assert property (@(negedge sclk)
        disable iff (cs_n)
        sdio_oe |-> $past(bidir))
        else $error("shared pin drove in separate-output mode");
endmodule

// ### srcp_host.sv
// Host serial master model: frames cycles and shifts bytes on both pins.
// Assumes the port splits its pins into value and enable.
`timescale 1ns/10ps
module srcp_host (
    // Serial link, host side.
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    // Pin drivers of the port.
    input logic sdio_out,
    input logic sdio_oe,
    input logic sdo_out,
    input logic sdo_oe
);
    logic host_oe = 1'b0;
    logic host_bit = 1'b0;
    logic last = 1'b0;
    logic [7:0] got_byte;
    event got;
    // An undriven wire shows the inverse of its last level, so a stale bit
    // never passes for read data.
    assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~last);
    always @(posedge sclk) last <= sdio_in;
    // Select rises after time zero so the port's asynchronous clear is
    // certain to see an edge.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        #1 cs_n = 1'b1;
    end
    // Clock pulses with select high, only used around reset.
    task pulse(input int n);
        repeat (n) begin
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
    endtask
    // A nonzero cut raises select after that many bits.
    task frame(input logic bidir, input logic lsb, input logic [7:0] instr,
               input logic [31:0] wd, input int cut, output logic bad);
        int nb;
        int k;
        logic [7:0] b;
        logic [7:0] r;
        logic line;
        nb = 8 + 8 * (int'(instr[6:5]) + 1);
        if (cut > 0) nb = cut;
        bad = 1'b0;
        cs_n = 1'b0;
        for (k = 0; k < nb; k++) begin
            b = (k < 8) ? instr : wd[8 * (k / 8 - 1) +: 8];
            host_oe = (k < 8) || !instr[7] || !bidir;
            host_bit = lsb ? b[k % 8] : b[7 - k % 8];
            #7.5;
            line = bidir ? sdio_in : (sdo_oe ? sdo_out : ~last);
            if (k >= 8 && instr[7]) begin
                if (lsb) r[k % 8] = line;
                else r[7 - k % 8] = line;
                if (bidir ? sdo_oe : sdio_oe) bad = 1'b1;
            end
            sclk = 1'b1;
            #7.5 sclk = 1'b0;
            if (k >= 8 && k % 8 == 7) begin
                got_byte = r;
                if (instr[7]) ->got;
                // A slow host lets each byte cross before the next.
                #500;
            end
        end
        #7.5 cs_n = 1'b1;
        host_oe = 1'b0;
    endtask
endmodule

// ### tb_top.sv
// Self-checking bench of the serial register control port.
// Assumes srcp_top and the host model srcp_host.
`timescale 1ns/10ps
module tb_top;
    logic core_clk, nrst, sclk, cs_n, sdio_in;
    logic sdio_out, sdio_oe, sdo_out, sdo_oe;
    logic wr_strobe, soft_rst, cfg_bidir, cfg_lsb_first, bad, bidir, lsb;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [255:0] reg_image;
    logic [7:0] regs [32];
    logic [13:0] exp_wr [$];
    logic [7:0] exp_rd [$];
    int mismatches, check_count, c;
    logic [4:0] a;
    srcp_top i_srcp_top (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
        .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
        .soft_rst(soft_rst), .cfg_bidir(cfg_bidir),
        .cfg_lsb_first(cfg_lsb_first), .reg_image(reg_image));
    srcp_host i_srcp_host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task cmp(input logic [255:0] got, input logic [255:0] exp,
             input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Strobes are sampled mid-cycle, where they stand settled.
    always @(negedge core_clk) begin
        if (nrst === 1'b1 && wr_strobe === 1'b1) begin
            if (exp_wr.size() == 0) cmp(1, 0, "extra write");
            else cmp({wr_addr, wr_data, soft_rst}, exp_wr.pop_front(),
                     "write");
        end
    end
    initial forever begin
        @(i_srcp_host.got);
        if (exp_rd.size() == 0) cmp(1, 0, "extra read");
        else cmp(i_srcp_host.got_byte, exp_rd.pop_front(), "read");
    end
    task xfer(input logic rd, input int cnt, input logic [4:0] a0,
              input logic [31:0] wd, input int cut);
        logic [4:0] p;
        logic [7:0] d;
        logic [255:0] img;
        int j;
        p = a0;
        for (j = 0; j < cnt; j++) begin
            d = wd[8 * j +: 8];
            if (rd) exp_rd.push_back(regs[p]);
            else if (cut == 0 || cut >= 16 + 8 * j) begin
                exp_wr.push_back({p, d, p == 5'h00 && d[5]});
                if (p != 5'h00) regs[p] = d;
                else if (!d[5]) regs[0] = {d[7:6], 1'b0, d[4:0]};
                else begin
                    regs[0] = {d[7:6], 1'b0, d[4:0]};
                    for (int i = 1; i < 32; i++) regs[i] = 8'h00;
                end
            end
            p = lsb ? p + 5'h01 : p - 5'h01;
        end
        @(negedge core_clk);
        i_srcp_host.frame(bidir, lsb, {rd, 2'(cnt - 1), a0}, wd, cut, bad);
        bidir = regs[0][7];
        lsb = regs[0][6];
        cmp(bad, 0, "pin use");
        repeat (8) @(negedge core_clk);
        cmp(sdio_oe | sdo_oe, 0, "float");
        cmp(exp_wr.size() + exp_rd.size(), 0, "pending");
        cmp({cfg_bidir, cfg_lsb_first}, {bidir, lsb}, "config");
        for (j = 0; j < 32; j++) img[8 * j +: 8] = regs[j];
        cmp(reg_image, img, "image");
    endtask
    initial begin
        #2_000_000;
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish;
    end
    initial begin
        nrst = 1'b0;
        bidir = 1'b0;
        lsb = 1'b0;
        for (int i = 0; i < 32; i++) regs[i] = 8'h00;
        void'($urandom(32'hB82C));
        // The link side sees reset only on serial edges, so give some.
        i_srcp_host.pulse(4);
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        i_srcp_host.pulse(4);
        xfer(1, 4, 5'h01, 0, 0);
        // Register 0 lies in this span, so its byte is kept at zero.
        xfer(0, 4, 5'h01, $urandom & 32'hFFFF00FF, 0);
        xfer(1, 4, 5'h01, 0, 0);
        $display("test msb wrap done");
        xfer(0, 1, 5'h00, 32'h40, 0);
        for (c = 1; c <= 4; c++) begin
            a = 5'($urandom_range(27, 1));
            xfer(0, c, a, $urandom, 0);
            xfer(1, c, a, 0, 0);
        end
        xfer(1, 2, 5'h1F, 0, 0);
        $display("test lsb done");
        xfer(0, 1, 5'h00, 32'hC0, 0);
        xfer(1, 3, 5'h1E, 0, 0);
        xfer(0, 1, 5'h00, 32'h80, 0);
        xfer(1, 2, 5'h1F, 0, 0);
        $display("test shared pin done");
        xfer(0, 1, 5'h00, 32'h00, 0);
        xfer(0, 2, 5'h05, $urandom, 20);
        xfer(1, 2, 5'h05, 0, 0);
        $display("test abort done");
        xfer(0, 4, 5'h08, $urandom, 0);
        xfer(0, 1, 5'h00, 32'h24, 0);
        xfer(1, 4, 5'h08, 0, 0);
        $display("test soft reset done");
        tally_and_finish;
    end
endmodule
